// ---- design/ldm_defines.vh ----
`ifndef LDM_DEFINES_VH
`define LDM_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LDM_ADDR_CHIP_EN      7'h00
`define LDM_ADDR_DEV_CFG      7'h01
`define LDM_ADDR_FLAGS        7'h02
`define LDM_ADDR_CLR_FLAGS    7'h03
`define LDM_ADDR_GLOBAL_SCALE 7'h66
`define LDM_ADDR_SW_RESET     7'h78

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define LDM_BIT_CHIP_EN       0
`define LDM_BIT_PSAVE_EN      0
`define LDM_BIT_MAX_CUR_OPT   1
`define LDM_BIT_FLAG_PREOTP   0
`define LDM_BIT_FLAG_PREUVLO  1
`define LDM_BIT_FLAG_OPEN     2
`define LDM_BIT_FLAG_SHORT    3
`define LDM_SW_RESET_KEY      8'hff
`define LDM_RST_CHIP_EN       1'h0
`define LDM_RST_DEV_CFG       2'h3
`define LDM_RST_GSCALE        6'h00
`define LDM_GAIN_BASE         8'h15
`define LDM_GAIN_STEP         8'h03
`define LDM_FRAME_BITS        5'h10

// ----------------------------------------------------------------
// timing, clock 20 mhz
// ----------------------------------------------------------------
`define LDM_CLK_HZ            20000000
`define LDM_RST_SHORT_MS      1
`define LDM_RST_LONG_MS       20
`define LDM_EN_OFF_MS         25
`define LDM_PSAVE_MS          30
`define LDM_CYC_PER_MS        (`LDM_CLK_HZ / 1000)

`endif

// ---- design/ldm_spi_slave.v ----
`timescale 1ns/1ps
// mode 0 spi slave; sclk and cs are already synchronised by the caller
module ldm_spi_slave (
  input  wire       clock,
  input  wire       ce,
  input  wire       srst,
  input  wire       sclk_s,
  input  wire       cs_n_s,
  input  wire       mosi_s,
  input  wire [7:0] rd_data,
  output reg        wr_stb,
  output reg        cmd_stb,
  output reg  [6:0] addr,
  output reg  [7:0] wr_data,
  output reg        miso,
  output reg        miso_oe
);
`include "ldm_defines.vh"

  reg        sclk_d_r;
  reg [4:0]  cnt_r;
  reg [15:0] sh_r;
  reg [7:0]  tx_r;
  reg        rd_r;
  wire       rise = sclk_s & ~sclk_d_r;
  wire       fall = ~sclk_s & sclk_d_r;

  always @(posedge clock) begin
    if (srst) begin
      sclk_d_r <= 1'b0;
      cnt_r    <= 5'h00;
      sh_r     <= 16'h0000;
      tx_r     <= 8'h00;
      rd_r     <= 1'b0;
      wr_stb   <= 1'b0;
      cmd_stb  <= 1'b0;
      addr     <= 7'h00;
      wr_data  <= 8'h00;
      miso     <= 1'b0;
      miso_oe  <= 1'b0;
    end else if (ce) begin
      sclk_d_r <= sclk_s;
      wr_stb   <= 1'b0;
      cmd_stb  <= 1'b0;
      miso_oe  <= ~cs_n_s;
      if (cs_n_s) begin
        cnt_r <= 5'h00;
        rd_r  <= 1'b0;
      end else begin
        if (rise && cnt_r != `LDM_FRAME_BITS) begin
          sh_r  <= {sh_r[14:0], mosi_s};
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == 5'h07) begin
            addr <= {sh_r[5:0], mosi_s};
            rd_r <= ~sh_r[6];
          end
          if (cnt_r == 5'h0f) begin
            cmd_stb <= 1'b1;
            if (sh_r[14]) begin
              wr_data <= {sh_r[6:0], mosi_s};
              wr_stb  <= 1'b1;
            end
          end
        end
        if (fall) begin
          if (cnt_r == 5'h08 && rd_r) begin
            miso <= rd_data[7];
            tx_r <= {rd_data[6:0], 1'b0};
          end else begin
            miso <= tx_r[7];
            tx_r <= {tx_r[6:0], 1'b0};
          end
        end
      end
    end
  end
endmodule

// ---- design/ldm_top.v ----
`timescale 1ns/1ps
// Notes on behaviour
// - fault output driven low while any unmasked fault condition is active.
// - only undervoltage lockout and over-temperature change mode; others only report.
// - spi slave used when interface select high; no i2c path, the spi is held idle when low.
// - digital logic enabled only while digital reset pin is high; only the spi slave is held in reset while it is low.
// - reset pin low 1 to 20 ms resets only the serial interface.
// - reset pin low over 20 ms returns all registers to defaults.
// - global dimming code 6 bits at 0x66; gain 21 plus 3 times n.
// - full scale current scaled by option/4 plus 3/4.
// - enable rising enters initialization and resets registers.
// - 0xff to software reset or undervoltage enters initialization.
// - device enable bit one enters normal mode.
// - power save after leds off over 30 ms when enabled.
// - any serial command in power save returns to normal.
// - enable low over 25 ms enters shutdown from any mode.
// - device enable zero enters standby; outputs off, registers kept.
// - over-temperature enters thermal shutdown until it clears.
// - serial data output high impedance until select goes low.
// - spi mode 0, sample on rising edge, clock idles low.
// - write bit one, seven address bits, eight data bits.
// - data committed on the final rising edge of the frame.
// - read when bit zero; unused addresses return zero.
// - read data driven on falling edges from the next cycle.
module ldm_top (
  input  wire       clock,
  input  wire       ce,
  input  wire       srst,
  input  wire       enable_pin,
  input  wire       digital_reset_pin_n,
  input  wire       interface_select_pin,
  input  wire       select_line_pin,
  input  wire       serial_clock_pin,
  input  wire       serial_data_pin_in,
  input  wire       undervoltage_lockout,
  input  wire       over_temperature,
  input  wire       early_undervoltage_warning,
  input  wire       early_over_temperature,
  input  wire       channel_open,
  input  wire       channel_short,
  input  wire       leds_all_off,
  output reg        serial_data_pin_out,
  output reg        serial_data_pin_oe,
  output reg        fault_pin_out,
  output reg        fault_pin_oe,
  output reg  [2:0] mode,
  output reg        outputs_enable,
  output reg        analog_enable,
  output reg  [7:0] current_gain,
  output reg        max_current_option,
  output reg  [5:0] global_dimming_code
);
`include "ldm_defines.vh"

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  localparam M_SHUTDOWN = 3'h0;
  localparam M_INIT     = 3'h1;
  localparam M_STANDBY  = 3'h2;
  localparam M_NORMAL   = 3'h3;
  localparam M_PSAVE    = 3'h4;
  localparam M_THERMAL  = 3'h5;

  localparam [31:0] RST_SHORT_CYC = `LDM_RST_SHORT_MS * `LDM_CYC_PER_MS;
  localparam [31:0] RST_LONG_CYC  = `LDM_RST_LONG_MS * `LDM_CYC_PER_MS;
  localparam [31:0] EN_OFF_CYC    = `LDM_EN_OFF_MS * `LDM_CYC_PER_MS;
  localparam [31:0] PSAVE_CYC     = `LDM_PSAVE_MS * `LDM_CYC_PER_MS;

  // gain = 21 + 3 * n, n is the code with its top bit inverted
  function [7:0] gain_of;
    input [5:0] code;
    reg   [5:0] n;
    begin
      n       = {~code[5], code[4:0]};
      gain_of = `LDM_GAIN_BASE + `LDM_GAIN_STEP * {2'h0, n};
    end
  endfunction

  // one decode for the software reset and clear-flags writes that a completed write frame targets
  function wr_hit;
    input       stb;
    input [6:0] a;
    input [6:0] target;
    begin
      wr_hit = stb && a == target;
    end
  endfunction

  // thermal shutdown keeps the analog side up; only the sinks are off
  function analog_on;
    input [2:0] m;
    begin
      analog_on = m == M_NORMAL || m == M_THERMAL;
    end
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg [12:0] s1_r;
  reg [12:0] s2_r;
  // select line resets to its idle high level, so no frame starts at release
  always @(posedge clock) begin
    if (srst) begin
      s1_r <= 13'h000a;
      s2_r <= 13'h000a;
    end else if (ce) begin
      s1_r <= {leds_all_off, channel_short, channel_open, early_over_temperature,
               early_undervoltage_warning, over_temperature, undervoltage_lockout,
               serial_data_pin_in, serial_clock_pin, select_line_pin,
               interface_select_pin, digital_reset_pin_n, enable_pin};
      s2_r <= s1_r;
    end
  end
  wire en_s    = s2_r[0];
  wire digital_reset_pin_s  = s2_r[1];
  wire spi_sel = s2_r[2];
  wire cs_n_s  = s2_r[3] | ~spi_sel;
  wire sclk_s  = s2_r[4] & spi_sel;
  wire mosi_s  = s2_r[5];
  wire undervoltage_lockout_s  = s2_r[6];
  wire otp_s   = s2_r[7];
  wire puv_s   = s2_r[8];
  wire pot_s   = s2_r[9];
  wire open_s  = s2_r[10];
  wire short_s = s2_r[11];
  wire off_s   = s2_r[12];

  // ----------------------------------------------------------------
  // reset pin pulse width decode
  // ----------------------------------------------------------------
  reg [31:0] rlow_r;
  reg        if_rst_r;
  reg        all_rst_r;
  always @(posedge clock) begin
    if (srst) begin
      rlow_r    <= 32'h00000000;
      if_rst_r  <= 1'b0;
      all_rst_r <= 1'b0;
    end else if (ce) begin
      if_rst_r  <= 1'b0;
      all_rst_r <= 1'b0;
      // counter saturates, so a very long low never wraps into a short pulse
      if (!digital_reset_pin_s) begin
        if (rlow_r != RST_LONG_CYC + 32'h1)
          rlow_r <= rlow_r + 32'h1;
        if (rlow_r == RST_LONG_CYC)
          all_rst_r <= 1'b1;
      end else begin
        rlow_r <= 32'h00000000;
        if (rlow_r >= RST_SHORT_CYC && rlow_r <= RST_LONG_CYC)
          if_rst_r <= 1'b1;
      end
    end
  end

  // spi logic held while the reset pin is low, or on a short pulse
  wire spi_rst = srst | ~digital_reset_pin_s | if_rst_r;

  // ----------------------------------------------------------------
  // spi slave
  // ----------------------------------------------------------------
  wire       wr_stb;
  wire       cmd_stb;
  wire [6:0] spi_addr;
  wire [7:0] spi_wdata;
  wire       spi_miso;
  wire       spi_oe;
  reg  [7:0] rd_data;

  ldm_spi_slave u_spi (
    .clock   (clock),
    .ce      (ce),
    .srst    (spi_rst),
    .sclk_s  (sclk_s),
    .cs_n_s  (cs_n_s),
    .mosi_s  (mosi_s),
    .rd_data (rd_data),
    .wr_stb  (wr_stb),
    .cmd_stb (cmd_stb),
    .addr    (spi_addr),
    .wr_data (spi_wdata),
    .miso    (spi_miso),
    .miso_oe (spi_oe)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg       chip_en_r;
  reg [1:0] dev_cfg_r;
  reg [5:0] gscale_r;
  reg [3:0] flags_r;
  reg       en_d_r;
  wire      en_rise  = en_s & ~en_d_r;
  wire      sw_reset = wr_hit(wr_stb, spi_addr, `LDM_ADDR_SW_RESET) &&
                       spi_wdata == `LDM_SW_RESET_KEY;
  // lockout and a long reset pin low return every register to its default
  wire      reg_rst  = en_rise | sw_reset | undervoltage_lockout_s | all_rst_r;
  wire [3:0] flag_set = {short_s, open_s, puv_s, pot_s};
  wire       clr_wr   = wr_hit(wr_stb, spi_addr, `LDM_ADDR_CLR_FLAGS);
  // level faults and latched flags both hold the pin low until cleared
  wire       fault_any = undervoltage_lockout_s | otp_s | (|flags_r) | (|flag_set);

  always @(posedge clock) begin
    if (srst) begin
      chip_en_r <= `LDM_RST_CHIP_EN;
      dev_cfg_r <= `LDM_RST_DEV_CFG;
      gscale_r  <= `LDM_RST_GSCALE;
      flags_r   <= 4'h0;
      en_d_r    <= 1'b0;
    end else if (ce) begin
      en_d_r <= en_s;
      if (reg_rst) begin
        chip_en_r <= `LDM_RST_CHIP_EN;
        dev_cfg_r <= `LDM_RST_DEV_CFG;
        gscale_r  <= `LDM_RST_GSCALE;
        flags_r   <= 4'h0;
      end else begin
        // set wins over clear
        flags_r <= (flags_r & ~(clr_wr ? spi_wdata[3:0] : 4'h0)) | flag_set;
        if (wr_stb) begin
          case (spi_addr)
            `LDM_ADDR_CHIP_EN:      chip_en_r <= spi_wdata[`LDM_BIT_CHIP_EN];
            `LDM_ADDR_DEV_CFG:      dev_cfg_r <= spi_wdata[1:0];
            `LDM_ADDR_GLOBAL_SCALE: gscale_r  <= spi_wdata[5:0];
            default:                chip_en_r <= chip_en_r;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always @* begin
    case (spi_addr)
      `LDM_ADDR_CHIP_EN:      rd_data = {7'h00, chip_en_r};
      `LDM_ADDR_DEV_CFG:      rd_data = {6'h00, dev_cfg_r};
      `LDM_ADDR_FLAGS:        rd_data = {1'b0, mode, flags_r};
      `LDM_ADDR_GLOBAL_SCALE: rd_data = {2'h0, gscale_r};
      default:                rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // mode machine
  // ----------------------------------------------------------------
  reg [2:0]  mode_nxt;
  reg [31:0] enlow_r;
  reg [31:0] off_r;
  wire       en_off_long = enlow_r > EN_OFF_CYC;
  wire       off_long    = off_r > PSAVE_CYC;
  // both windows saturate; they span tens of ms at this clock

  always @(posedge clock) begin
    if (srst) begin
      enlow_r <= 32'h00000000;
      off_r   <= 32'h00000000;
    end else if (ce) begin
      if (en_s)
        enlow_r <= 32'h00000000;
      else if (!en_off_long)
        enlow_r <= enlow_r + 32'h1;
      if (!off_s || mode != M_NORMAL)
        off_r <= 32'h00000000;
      else if (!off_long)
        off_r <= off_r + 32'h1;
    end
  end

  // only undervoltage_lockout and otp act; other faults only report
  always @* begin
    mode_nxt = mode;
    if (en_off_long)
      mode_nxt = M_SHUTDOWN;
    else if (undervoltage_lockout_s || sw_reset || en_rise)
      mode_nxt = M_INIT;
    else begin
      case (mode)
        M_SHUTDOWN: mode_nxt = en_s ? M_INIT : M_SHUTDOWN;
        // init lasts one cycle after its cause ends; the registers are already at defaults there
        M_INIT:     mode_nxt = chip_en_r ? M_NORMAL : M_STANDBY;
        M_STANDBY:  mode_nxt = chip_en_r ? M_NORMAL : M_STANDBY;
        M_NORMAL: begin
          if (otp_s)
            mode_nxt = M_THERMAL;
          else if (!chip_en_r)
            mode_nxt = M_STANDBY;
          else if (dev_cfg_r[`LDM_BIT_PSAVE_EN] && off_long)
            mode_nxt = M_PSAVE;
        end
        M_PSAVE: begin
          if (otp_s)
            mode_nxt = M_THERMAL;
          else if (!chip_en_r)
            mode_nxt = M_STANDBY;
          else if (cmd_stb)
            mode_nxt = M_NORMAL;
        end
        M_THERMAL:  mode_nxt = otp_s ? M_THERMAL : M_NORMAL;
        default:    mode_nxt = M_SHUTDOWN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (srst) begin
      mode                <= M_SHUTDOWN;
      outputs_enable      <= 1'b0;
      analog_enable       <= 1'b0;
      fault_pin_out       <= 1'b0;
      fault_pin_oe        <= 1'b0;
      serial_data_pin_out <= 1'b0;
      serial_data_pin_oe  <= 1'b0;
      current_gain        <= 8'h00;
      max_current_option  <= 1'b1;
      global_dimming_code <= 6'h00;
    end else if (ce) begin
      mode           <= mode_nxt;
      outputs_enable <= mode_nxt == M_NORMAL;
      analog_enable  <= analog_on(mode_nxt);
      fault_pin_out  <= 1'b0;
      fault_pin_oe   <= fault_any;
      serial_data_pin_out <= spi_miso;
      serial_data_pin_oe  <= spi_oe & spi_sel;
      current_gain        <= gain_of(gscale_r);
      max_current_option  <= dev_cfg_r[`LDM_BIT_MAX_CUR_OPT];
      global_dimming_code <= gscale_r;
    end
  end
endmodule

// ---- test/ldm_chk_sva.sv ----
`timescale 1ns/1ps
module ldm_chk (
  input wire       clock,
  input wire       srst,
  input wire       enable_pin,
  input wire       interface_select_pin,
  input wire       select_line_pin,
  input wire       undervoltage_lockout,
  input wire       over_temperature,
  input wire       fault_pin_out,
  input wire       fault_pin_oe,
  input wire       serial_data_pin_oe,
  input wire [2:0] mode,
  input wire [7:0] current_gain,
  input wire [5:0] global_dimming_code
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // inputs cross two flops, so the windows allow a few cycles of lag
  property p_od; fault_pin_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("fault pin driven high");
  property p_fault; over_temperature [*5] |-> fault_pin_oe; endproperty
  a_fault: assert property (p_fault) else $error("fault pin idle");
  property p_therm;
    (over_temperature && !undervoltage_lockout && mode == 3'h3) [*2] |-> ##[0:6] mode == 3'h5;
  endproperty
  a_therm: assert property (p_therm) else $error("no thermal shutdown");
  property p_gain;
    $stable(global_dimming_code) [*3] |->
      current_gain == 8'h15 + 8'h03 * {2'h0, ~global_dimming_code[5], global_dimming_code[4:0]};
  endproperty
  a_gain: assert property (p_gain) else $error("gain mismatch");
  property p_idle; select_line_pin [*5] |-> !serial_data_pin_oe; endproperty
  a_idle: assert property (p_idle) else $error("data out driven");
  property p_i2c; !interface_select_pin [*5] |-> !serial_data_pin_oe; endproperty
  a_i2c: assert property (p_i2c) else $error("spi active in i2c");
  property p_en;
    $rose(enable_pin) && mode == 3'h0 && !undervoltage_lockout |-> ##[1:8] mode == 3'h1;
  endproperty
  a_en: assert property (p_en) else $error("no init on enable");
  property p_uv; (undervoltage_lockout && enable_pin) [*4] |-> ##[0:4] mode == 3'h1; endproperty
  a_uv: assert property (p_uv) else $error("no init on lockout");
endmodule
bind ldm_top ldm_chk ldm_chk_inst (.*);

// ---- test/ldm_spi_host.sv ----
`timescale 1ns/1ps
module ldm_spi_host (
  input  wire clock,
  input  wire serial_data_pin_out,
  input  wire serial_data_pin_oe,
  output reg  select_line_pin = 1'b1,
  output reg  serial_clock_pin = 1'b0,
  output reg  serial_data_pin_in = 1'b0
);
  reg  last_r = 1'b0;
  // undriven line floats: show the inverse of the last driven bit
  wire miso = serial_data_pin_oe ? serial_data_pin_out : ~last_r;
  always @(posedge clock) if (serial_data_pin_oe) last_r <= serial_data_pin_out;
  task automatic xfer(input [15:0] f, input integer nb, output [7:0] rd);
    integer i;
    begin
      rd = 8'h00;
      select_line_pin <= 1'b0;
      for (i = 15; i > 15 - nb; i = i - 1) begin
        serial_data_pin_in <= f[i];
        repeat (4) @(posedge clock);
        serial_clock_pin <= 1'b1;
        repeat (4) @(posedge clock);
        // taken late in the high phase, since the slave lags its falling edge
        if (i < 8) rd[i] = miso;
        serial_clock_pin <= 1'b0;
      end
      repeat (8) @(posedge clock);
      select_line_pin <= 1'b1;
      serial_data_pin_in <= ~serial_data_pin_in;
      repeat (8) @(posedge clock);
    end
  endtask
endmodule

// ---- test/ldm_top_tb_top.sv ----
`timescale 1ns/1ps
module ldm_top_tb_top;
  reg        clock = 1'b0;
  reg        ce = 1'b1;
  reg        srst = 1'b1;
  reg        enable_pin = 1'b0;
  reg        digital_reset_pin_n = 1'b1;
  reg        interface_select_pin = 1'b1;
  reg        undervoltage_lockout = 1'b0;
  reg        over_temperature = 1'b0;
  reg        leds_all_off = 1'b0;
  reg  [3:0] flt = 4'h0;
  wire       early_over_temperature = flt[0];
  wire       early_undervoltage_warning = flt[1];
  wire       channel_open = flt[2];
  wire       channel_short = flt[3];
  wire       select_line_pin, serial_clock_pin, serial_data_pin_in;
  wire       serial_data_pin_out, serial_data_pin_oe, fault_pin_out, fault_pin_oe;
  wire       outputs_enable, analog_enable, max_current_option;
  wire [2:0] mode;
  wire [7:0] current_gain;
  wire [5:0] global_dimming_code;
  integer    num_errors = 0;
  integer    comparisons = 0;
  integer    cyc = 0;
  integer    i;
  reg  [7:0] d;
  reg  [5:0] c;

  always #25 clock = ~clock;
  ldm_top ldm_top_inst (.*);
  ldm_spi_host ldm_spi_host_inst (.*);

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic wt(input integer n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task automatic cm(input [2:0] e);
    chk("mode", {5'h00, mode}, {5'h00, e});
  endtask
  task automatic cb(input string nm, input b, input e);
    chk(nm, {7'h00, b}, {7'h00, e});
  endtask
  task automatic wr(input [6:0] a, input [7:0] v);
    begin
      ldm_spi_host_inst.xfer({1'b1, a, v}, 16, d);
      wt(4);
    end
  endtask
  task automatic rd(input [6:0] a, input [7:0] exp);
    begin
      ldm_spi_host_inst.xfer({1'b0, a, 8'h00}, 16, d);
      chk("read data", d, exp);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // run is about 35000 cycles, mostly the reset pin pulse
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      num_errors = num_errors + 1;
      conclude;
    end
  end

  initial begin
    wt(20);
    srst <= 1'b0;
    wt(4);
    cm(3'h0);
    enable_pin <= 1'b1;
    wt(8);
    cm(3'h2);
    cb("analog", analog_enable, 1'b0);
    chk("gain", current_gain, 8'h75);
    cb("range", max_current_option, 1'b1);
    rd(7'h66, 8'h00);
    rd(7'h01, 8'h03);
    $display("test reset done");
    wr(7'h00, 8'h01);
    cm(3'h3);
    cb("outs", outputs_enable, 1'b1);
    cb("analog", analog_enable, 1'b1);
    wr(7'h00, 8'h00);
    cm(3'h2);
    cb("outs", outputs_enable, 1'b0);
    rd(7'h00, 8'h00);
    wr(7'h00, 8'h01);
    $display("test modes done");
    for (i = 0; i < 4; i = i + 1) begin
      c = {i[1], {5{i[0]}}};
      wr(7'h66, {2'h0, c});
      chk("code", {2'h0, global_dimming_code}, {2'h0, c});
      chk("gain", current_gain, 8'h15 + 8'h03 * {2'h0, ~c[5], c[4:0]});
      rd(7'h66, {2'h0, c});
    end
    wr(7'h01, 8'h01);
    cb("range", max_current_option, 1'b0);
    wr(7'h01, 8'h03);
    cb("range", max_current_option, 1'b1);
    $display("test scaling done");
    rd(7'h7f, 8'h00);
    ldm_spi_host_inst.xfer({1'b1, 7'h66, 8'h2a}, 10, d);
    rd(7'h66, 8'h3f);
    interface_select_pin <= 1'b0;
    wr(7'h66, 8'h2a);
    interface_select_pin <= 1'b1;
    wt(4);
    rd(7'h66, 8'h3f);
    $display("test refusals done");
    for (i = 0; i < 4; i = i + 1) begin
      flt <= 4'h1 << i;
      wt(8);
      cb("fault", fault_pin_oe, 1'b1);
      cm(3'h3);
      flt <= 4'h0;
      wt(4);
      cb("fault", fault_pin_oe, 1'b1);
      wr(7'h03, 8'h0f);
      cb("fault", fault_pin_oe, 1'b0);
    end
    over_temperature <= 1'b1;
    wt(8);
    cm(3'h5);
    cb("outs", outputs_enable, 1'b0);
    cb("fault", fault_pin_oe, 1'b1);
    over_temperature <= 1'b0;
    wt(8);
    cm(3'h3);
    undervoltage_lockout <= 1'b1;
    wt(8);
    cm(3'h1);
    undervoltage_lockout <= 1'b0;
    wt(4);
    rd(7'h66, 8'h00);
    wr(7'h00, 8'h01);
    wr(7'h66, 8'h15);
    wr(7'h78, 8'hff);
    cm(3'h2);
    rd(7'h66, 8'h00);
    $display("test faults done");
    wr(7'h66, 8'h15);
    digital_reset_pin_n <= 1'b0;
    wt(100);
    wr(7'h66, 8'h2a);
    wt(29700);
    digital_reset_pin_n <= 1'b1;
    wt(8);
    rd(7'h66, 8'h15);
    $display("test reset pin done");
    conclude;
  end
endmodule
